// ### inc/sri_pkg.sv
// Purpose: Shared types and constants for the soft reset / interrupt return unit
// Assumes: 8-bit data path, 21-bit program counter
// Notes: Quarter phases and states are Gray coded
`default_nettype none
package sri_pkg;
  localparam int PC_W = 21;
  localparam int DATA_W = 8;
  localparam int HOLD_W = 8;
  localparam logic [HOLD_W-1:0] HOLD_RESET = 8'h00;
  localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
  localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
  localparam int SOFT_RESET_CYCLES_DEF = 4;

  typedef enum logic [1:0] {
    PH_Q1 = 2'h0,
    PH_Q2 = 2'h1,
    PH_Q3 = 2'h3,
    PH_Q4 = 2'h2
  } sri_phase_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_RFI_C1 = 2'h1,
    ST_RFI_C2 = 2'h3,
    ST_RESET = 2'h2
  } sri_fsm_t;

  typedef enum logic [1:0] {
    OP_NONE = 2'h0,
    OP_SOFT_RESET = 2'h1,
    OP_RETURN_INT = 2'h2
  } sri_op_t;

  typedef struct packed {
    logic [DATA_W-1:0] working;
    logic [DATA_W-1:0] flags;
    logic [DATA_W-1:0] bank_select;
  } sri_regs_t;

  localparam sri_regs_t REGS_RESET = '{working: DATA_RESET, flags: DATA_RESET, bank_select: DATA_RESET};

  typedef struct packed {
    sri_phase_t phase;
    sri_fsm_t st;
    logic restore_sel;
    logic high_sel;
    logic [HOLD_W-1:0] hold;
    logic instr_ready;
    logic pc_load;
    logic [PC_W-1:0] pc_value;
    logic stack_pop;
    logic high_en_set;
    logic low_en_set;
    logic restore_valid;
    sri_regs_t restore_data;
    logic core_reset_n;
  } sri_state_t;

  localparam sri_state_t STATE_RESET = '{
    phase: PH_Q1, st: ST_IDLE, restore_sel: 1'b0, high_sel: 1'b0, hold: HOLD_RESET,
    instr_ready: 1'b0, pc_load: 1'b0, pc_value: PC_RESET, stack_pop: 1'b0,
    high_en_set: 1'b0, low_en_set: 1'b0, restore_valid: 1'b0, restore_data: REGS_RESET,
    core_reset_n: 1'b0};
endpackage
`default_nettype wire

// ### logic/sri_unit.sv
// Purpose: Executes the software reset and return-from-interrupt instructions
// Assumes: Inputs synchronous to clk_sys; one quarter phase per clock
// Notes: core_reset_n is the common reset path for pin and software
//
// How it works
// RULE1: Software reset restores all reset values
// RULE2: Software reset drives the master-clear reset path
// RULE3: Return loads PC from stack, sets enable
// RULE4: Shadow select restores working, flags, bank
// RULE5: PC latches never written by return
// RULE6: Reset one cycle from Q2; return two cycles
`default_nettype none
module sri_unit
  import sri_pkg::*;
#(
  parameter int SOFT_RESET_CYCLES = SOFT_RESET_CYCLES_DEF
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic instr_valid,
  input wire sri_pkg::sri_op_t instr_op,
  input wire logic instr_shadow_sel,
  input wire logic irq_priority_mode,
  input wire logic irq_high_active,
  input wire logic [sri_pkg::PC_W-1:0] return_stack_top,
  input wire sri_pkg::sri_regs_t shadow_regs,
  output sri_pkg::sri_phase_t quarter_phase,
  output logic instr_ready,
  output logic pc_load,
  output logic [sri_pkg::PC_W-1:0] pc_value,
  output logic stack_pop,
  output logic global_high_irq_enable_set,
  output logic peripheral_low_irq_enable_set,
  output logic restore_valid,
  output sri_pkg::sri_regs_t restore_data,
  output logic core_reset_n
);
  import sri_pkg::*;

  if (SOFT_RESET_CYCLES < 1 || SOFT_RESET_CYCLES > 255) begin : bad_reset_cycles
    $error("SOFT_RESET_CYCLES must be 1..255");
  end

  localparam logic [HOLD_W-1:0] HOLD_LOAD = HOLD_W'(SOFT_RESET_CYCLES - 1);

  logic rst_meta;
  logic rst_sync;
  sri_state_t s;
  sri_state_t next_s;
  logic accept;

  // Reset release synchroniser
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  assign accept = instr_valid && s.st == ST_IDLE && s.phase == PH_Q1 && s.core_reset_n;

  always_comb begin
    next_s = s;
    next_s.pc_load = 1'b0;
    next_s.stack_pop = 1'b0;
    next_s.high_en_set = 1'b0;
    next_s.low_en_set = 1'b0;
    next_s.restore_valid = 1'b0;
    case (s.phase)
      PH_Q1: next_s.phase = PH_Q2;
      PH_Q2: next_s.phase = PH_Q3;
      PH_Q3: next_s.phase = PH_Q4;
      default: next_s.phase = PH_Q1;
    endcase
    case (s.st)
      ST_IDLE: begin
        next_s.core_reset_n = 1'b1; // RULE2
        if (accept && instr_op == OP_SOFT_RESET) begin
          next_s.st = ST_RESET;
        end else if (accept && instr_op == OP_RETURN_INT) begin
          next_s.st = ST_RFI_C1;
          next_s.restore_sel = instr_shadow_sel;
          next_s.high_sel = !irq_priority_mode || irq_high_active;
        end
      end
      ST_RESET: begin
        if (s.core_reset_n && s.phase == PH_Q2) begin
          next_s.core_reset_n = 1'b0; // RULE2 RULE6
          next_s.hold = HOLD_LOAD;
        end else if (!s.core_reset_n) begin
          if (s.hold != HOLD_RESET) begin
            next_s.hold = s.hold - 8'h01;
          end else begin
            next_s = STATE_RESET; // RULE1
            next_s.core_reset_n = 1'b1;
          end
        end
      end
      ST_RFI_C1: begin
        if (s.phase == PH_Q4) begin
          next_s.st = ST_RFI_C2;
          next_s.pc_load = 1'b1; // RULE3
          next_s.pc_value = return_stack_top; // RULE3 RULE5
          next_s.stack_pop = 1'b1; // RULE3
          next_s.high_en_set = s.high_sel; // RULE3
          next_s.low_en_set = !s.high_sel; // RULE3
          next_s.restore_valid = s.restore_sel; // RULE4
          if (s.restore_sel) begin
            next_s.restore_data = shadow_regs; // RULE4
          end
        end
      end
      default: begin
        if (s.phase == PH_Q4) begin
          next_s.st = ST_IDLE; // RULE6
        end
      end
    endcase
    next_s.instr_ready = next_s.st == ST_IDLE && next_s.core_reset_n;
  end

  always_ff @(posedge clk_sys or negedge rst_sync) begin
    if (!rst_sync) begin
      s <= STATE_RESET;
    end else begin
      s <= next_s;
    end
  end

  // Marks the first edge after release, for the checks
  logic out_of_reset;
  always_ff @(posedge clk_sys or negedge rst_sync) begin
    if (!rst_sync) begin
      out_of_reset <= 1'b0;
    end else begin
      out_of_reset <= 1'b1;
    end
  end

  assign quarter_phase = s.phase;
  assign instr_ready = s.instr_ready;
  assign pc_load = s.pc_load;
  assign pc_value = s.pc_value;
  assign stack_pop = s.stack_pop;
  assign global_high_irq_enable_set = s.high_en_set;
  assign peripheral_low_irq_enable_set = s.low_en_set;
  assign restore_valid = s.restore_valid;
  assign restore_data = s.restore_data;
  assign core_reset_n = s.core_reset_n;

  // Checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_sync);

  logic first_done;
  always_ff @(posedge clk_sys or negedge rst_sync) begin
    if (!rst_sync) begin
      first_done <= 1'b0;
    end else begin
      first_done <= out_of_reset;
    end
  end

  // Counts cycles the core reset is held low
  logic [HOLD_W:0] low_count;
  always_ff @(posedge clk_sys or negedge rst_sync) begin
    if (!rst_sync) begin
      low_count <= '0;
    end else if (!s.core_reset_n) begin
      low_count <= low_count + (HOLD_W+1)'(1);
    end else begin
      low_count <= '0;
    end
  end

  soft_reset_path_a: assert property (accept && instr_op == OP_SOFT_RESET |-> ##2 !core_reset_n) // RULE2
    else $error("Soft reset did not assert core reset at Q2");
  reset_clears_a: assert property (!s.core_reset_n |-> !pc_load && !stack_pop && !restore_valid && !instr_ready) // RULE1
    else $error("Outputs active during soft reset");
  reset_release_a: assert property ($fell(s.core_reset_n) |-> ##[1:300] (s.core_reset_n && pc_value == PC_RESET)) // RULE1
    else $error("Soft reset did not release with reset values");
  pc_from_stack_a: assert property (pc_load |-> stack_pop && pc_value == $past(return_stack_top)) // RULE3
    else $error("PC not loaded from stack top");
  one_enable_a: assert property (pc_load |-> (global_high_irq_enable_set ^ peripheral_low_irq_enable_set)) // RULE3
    else $error("Return did not set exactly one enable");
  shadow_copy_a: assert property (restore_valid |-> pc_load && restore_data == $past(shadow_regs)) // RULE4
    else $error("Shadow restore mismatch");
  no_shadow_a: assert property (accept && instr_op == OP_RETURN_INT && !instr_shadow_sel |-> !restore_valid[*8]) // RULE4
    else $error("Restore without shadow select");
  pc_only_load_a: assert property (first_done && $changed(pc_value) && s.core_reset_n && $past(s.core_reset_n) |-> pc_load) // RULE5
    else $error("PC changed outside a return");
  return_timing_a: assert property (accept && instr_op == OP_RETURN_INT |-> ##4 pc_load ##4 instr_ready) // RULE6
    else $error("Return not two instruction cycles");
  phase_wrap_a: assert property (quarter_phase == PH_Q4 |=> quarter_phase == PH_Q1) // RULE6
    else $error("Quarter phase did not wrap to Q1");
  pulse_single_a: assert property (pc_load |=> !pc_load) // RULE6
    else $error("PC load pulse longer than one cycle");
  second_nop_a: assert property (pc_load |=> (!pc_load && !stack_pop && !restore_valid)[*7]) // RULE6
    else $error("Second return cycle not a no-op");
  reset_in_q2_a: assert property ($fell(s.core_reset_n) |-> $past(quarter_phase) == PH_Q2) // RULE6
    else $error("Soft reset did not start in Q2");
  release_values_a: assert property (first_done && $rose(s.core_reset_n) |-> instr_ready && quarter_phase == PH_Q1 // RULE1
    && pc_value == PC_RESET && restore_data == REGS_RESET)
    else $error("Soft reset released without reset values");
  reset_length_a: assert property (first_done && $rose(s.core_reset_n) |-> low_count == (HOLD_W+1)'(SOFT_RESET_CYCLES)) // RULE2
    else $error("Soft reset held for wrong number of cycles");
  enable_high_a: assert property (accept && instr_op == OP_RETURN_INT && !irq_priority_mode // RULE3
    |-> ##4 global_high_irq_enable_set)
    else $error("High enable not set on return");
  enable_low_a: assert property (accept && instr_op == OP_RETURN_INT && irq_priority_mode && !irq_high_active // RULE3
    |-> ##4 peripheral_low_irq_enable_set)
    else $error("Low enable not set on return");
  instr_refused_a: assert property (instr_valid && instr_ready && quarter_phase != PH_Q1 |=> instr_ready && core_reset_n) // RULE6
    else $error("Instruction taken outside Q1");

  soft_reset_c: cover property (accept && instr_op == OP_SOFT_RESET ##2 !core_reset_n);
  return_shadow_c: cover property (restore_valid);
  return_low_c: cover property (peripheral_low_irq_enable_set);
  return_plain_c: cover property (pc_load && !restore_valid);
  soft_release_c: cover property (first_done && $rose(s.core_reset_n));
endmodule
`default_nettype wire

// ### verification/tb_sri_unit.sv
// Purpose: Self-checking bench for the soft reset / interrupt return unit
// Assumes: Inputs driven at the falling edge of clk_sys
// Notes: Software reset count set via SOFT_RESET_CYCLES to 4, the same as the default
`default_nettype none
module tb_sri_unit;
  timeunit 1ns;
  timeprecision 1ps;
  import sri_pkg::*;
  localparam int SR_CYC = 4;
  logic clk_sys, resetn, instr_valid, instr_shadow_sel, irq_priority_mode, irq_high_active;
  sri_op_t instr_op;
  logic [PC_W-1:0] return_stack_top, pc_value;
  sri_regs_t shadow_regs, restore_data;
  sri_phase_t quarter_phase;
  logic instr_ready, pc_load, stack_pop, hi_set, lo_set, restore_valid, core_reset_n;
  int fails = 0;
  int n_checks = 0;
  int cyc = 0;
  int n;
  sri_unit #(.SOFT_RESET_CYCLES(SR_CYC)) dut (.clk_sys(clk_sys), .resetn(resetn), .instr_valid(instr_valid),
    .instr_op(instr_op), .instr_shadow_sel(instr_shadow_sel), .irq_priority_mode(irq_priority_mode),
    .irq_high_active(irq_high_active), .return_stack_top(return_stack_top), .shadow_regs(shadow_regs),
    .quarter_phase(quarter_phase), .instr_ready(instr_ready), .pc_load(pc_load), .pc_value(pc_value),
    .stack_pop(stack_pop), .global_high_irq_enable_set(hi_set), .peripheral_low_irq_enable_set(lo_set),
    .restore_valid(restore_valid), .restore_data(restore_data), .core_reset_n(core_reset_n));
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      complete_run();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Offer one instruction at the next ready Q1; returns one edge after acceptance
  task automatic issue(input sri_op_t op, input logic s);
    n = 0;
    @(negedge clk_sys);
    while (!(instr_ready === 1'b1 && quarter_phase === PH_Q1) && n < 100) begin
      @(negedge clk_sys);
      n++;
    end
    instr_valid = 1'b1;
    instr_op = op;
    instr_shadow_sel = s;
    @(posedge clk_sys);
    @(negedge clk_sys);
    instr_valid = 1'b0;
    instr_op = OP_NONE;
  endtask
  task automatic ret(input logic s, input logic mode, input logic hact, input logic [PC_W-1:0] pc,
                     input sri_regs_t sh, input logic exp_hi, input sri_regs_t exp_rd);
    irq_priority_mode = mode;
    irq_high_active = hact;
    return_stack_top = pc;
    shadow_regs = sh;
    issue(OP_RETURN_INT, s);
    check(32'(instr_ready), 32'h0);
    repeat (3) @(negedge clk_sys);
    check(32'(pc_load), 32'h1);
    check(32'(stack_pop), 32'h1);
    check(32'(pc_value), 32'(pc));
    check(32'(hi_set), 32'(exp_hi));
    check(32'(lo_set), 32'(!exp_hi));
    check(32'(restore_valid), 32'(s));
    check(32'(restore_data), 32'(exp_rd));
    @(negedge clk_sys);
    check(32'({pc_load, stack_pop, hi_set, lo_set, restore_valid}), 32'h0);
    check(32'(pc_value), 32'(pc));
    repeat (2) @(negedge clk_sys);
    check(32'(instr_ready), 32'h0);
    @(negedge clk_sys);
    check(32'(instr_ready), 32'h1);
    check(32'(quarter_phase), 32'(PH_Q1));
  endtask
  initial begin
    resetn = 1'b0;
    instr_valid = 1'b0;
    instr_op = OP_NONE;
    instr_shadow_sel = 1'b0;
    irq_priority_mode = 1'b0;
    irq_high_active = 1'b0;
    return_stack_top = '0;
    shadow_regs = REGS_RESET;
    repeat (6) @(negedge clk_sys);
    resetn = 1'b1;
    repeat (6) @(negedge clk_sys);
    check(32'(core_reset_n), 32'h1);
    check(32'(pc_value), 32'h0);
    ret(1'b1, 1'b0, 1'b0, 21'h1ABCDE, '{8'h5A, 8'hC3, 8'h0F}, 1'b1, '{8'h5A, 8'hC3, 8'h0F});
    @(negedge clk_sys);
    instr_valid = 1'b1;
    instr_op = OP_SOFT_RESET;
    repeat (3) @(negedge clk_sys);
    instr_valid = 1'b0;
    instr_op = OP_NONE;
    repeat (3) @(negedge clk_sys);
    check(32'({core_reset_n, instr_ready}), 32'h3);
    ret(1'b0, 1'b1, 1'b0, 21'h00F0F1, '{8'h11, 8'h22, 8'h33}, 1'b0, '{8'h5A, 8'hC3, 8'h0F});
    ret(1'b1, 1'b1, 1'b1, 21'h000002, '{8'hA5, 8'h3C, 8'hF0}, 1'b1, '{8'hA5, 8'h3C, 8'hF0});
    issue(OP_SOFT_RESET, 1'b0);
    check(32'(core_reset_n), 32'h1);
    @(negedge clk_sys);
    check(32'(core_reset_n), 32'h0);
    n = 1;
    while (core_reset_n === 1'b0 && n < 50) begin
      @(negedge clk_sys);
      n++;
    end
    check(32'(n - 1), 32'(SR_CYC));
    check(32'(quarter_phase), 32'(PH_Q1));
    check(32'(instr_ready), 32'h1);
    check(32'(pc_value), 32'h0);
    check(32'(restore_data), 32'h0);
    ret(1'b1, 1'b1, 1'b0, 21'h155555, '{8'h01, 8'h80, 8'h7E}, 1'b0, '{8'h01, 8'h80, 8'h7E});
    complete_run();
  end
endmodule
`default_nettype wire
